/* File: sfsr_pkg.sv */
// constants shared by the serial flash status register logic
package sfsr_pkg;

   // ****************************************************
   // status byte one field positions
   // ****************************************************
   localparam int LOCK_POS = 7;
   localparam int FAIL_POS = 5;
   localparam int PIN_POS = 4;
   localparam int SWP_HI = 3;
   localparam int SWP_LO = 2;
   localparam int LATCH_POS = 1;
   localparam int BUSY_POS = 0;

   // ****************************************************
   // status byte two field positions
   // ****************************************************
   localparam int RST_ALLOW_POS = 4;
   localparam int LCK_ALLOW_POS = 3;

   // ****************************************************
   // write-status-byte-1 data layout
   // ****************************************************
   localparam int GCODE_HI = 5;
   localparam int GCODE_LO = 2;

   // ****************************************************
   // reset values
   // ****************************************************
   localparam logic LOCK_RST = 1'b0;
   localparam logic LATCH_RST = 1'b0;
   localparam logic FAIL_RST = 1'b0;
   localparam logic RST_ALLOW_RST = 1'b0;
   localparam logic LCK_ALLOW_RST = 1'b0;

   // ****************************************************
   // soft protection summary codes
   // ****************************************************
   localparam logic [1:0] SWP_NONE = 2'h0;
   localparam logic [1:0] SWP_SOME = 2'h1;
   localparam logic [1:0] SWP_ALL = 2'h3;

   // ****************************************************
   // opcodes and confirmation byte
   // ****************************************************
   localparam logic [7:0] OP_WSR1 = 8'h01;
   localparam logic [7:0] OP_WSR2 = 8'h31;
   localparam logic [7:0] OP_SRST = 8'hF0;
   localparam logic [7:0] SRST_CONFIRM = 8'hD0;

   // ****************************************************
   // serial framing
   // ****************************************************
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [1:0] BYTE_MAX = 2'h3;

endpackage

/* File: sfsr_core.sv */
// status register logic of a serial flash, behind the spi pins
`timescale 1ns/1ps
module sfsr_core #(
   parameter logic [7:0] OP_WREN = 8'h06,
   parameter logic [7:0] OP_WRDI = 8'h04,
   parameter logic [7:0] OP_RDSR = 8'h05,
   parameter logic [7:0] OP_PROT = 8'h36,
   parameter logic [7:0] OP_UNPROT = 8'h39,
   parameter logic [7:0] OP_LOCKDN = 8'h33,
   parameter logic [7:0] OP_FREEZE = 8'h34,
   parameter int N_OTHER = 8,
   // program, erases and otp program, one byte each
   parameter logic [N_OTHER*8-1:0] OTHER_OPS = 64'h02_20_52_D8_60_C7_9B_A2
) (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic sck_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   input wire logic hold_n_in,
   input wire logic wp_n_in,
   input wire logic op_busy_in,
   input wire logic op_done_in,
   input wire logic op_fail_in,
   input wire logic op_abort_in,
   input wire logic freeze_done_in,
   input wire logic prot_none_in,
   input wire logic prot_all_in,
   output logic miso_out,
   output logic miso_oe_n_out,
   output logic [7:0] status_one_out,
   output logic [7:0] status_two_out,
   output logic [7:0] cmd_opcode_out,
   output logic cmd_accept_out,
   output logic global_req_out,
   output logic [3:0] global_code_out,
   output logic soft_reset_out
);
   import sfsr_pkg::*;

   // ****************************************************
   // parameter check
   // ****************************************************
   if (N_OTHER < 1) begin : g_bad
      $error("sfsr_core: N_OTHER must be at least one");
   end

   // ****************************************************
   // pin synchronisers
   // ****************************************************
   logic [1:0] sck_s, cs_s, mosi_s, hold_s, wp_s;
   logic sck_d, cs_d;

   // two flops per pin; only stage one feeds stage two
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         sck_s <= 2'h0;
         cs_s <= 2'h3;
         mosi_s <= 2'h0;
         hold_s <= 2'h3;
         wp_s <= 2'h3;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end else begin
         sck_s <= {sck_s[0], sck_in};
         cs_s <= {cs_s[0], cs_n_in};
         mosi_s <= {mosi_s[0], mosi_in};
         hold_s <= {hold_s[0], hold_n_in};
         wp_s <= {wp_s[0], wp_n_in};
         sck_d <= sck_s[1];
         cs_d <= cs_s[1];
      end
   end

   logic in_frame, sck_rise, sck_fall, cs_rise, cs_fall, wp_on;
   assign in_frame = ~cs_s[1];
   assign sck_rise = in_frame & sck_s[1] & ~sck_d;
   assign sck_fall = in_frame & ~sck_s[1] & sck_d;
   assign cs_rise = cs_s[1] & ~cs_d;
   assign cs_fall = ~cs_s[1] & cs_d;
   assign wp_on = ~wp_s[1];

   // ****************************************************
   // receive shifter and byte framing
   // ****************************************************
   logic [6:0] shift_in;
   logic [2:0] bit_cnt;
   logic [1:0] byte_cnt;
   logic [7:0] opcode, data_one, data_two;

   // bytes past the third are neither counted nor stored
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || cs_fall) begin
         shift_in <= 7'h00;
         bit_cnt <= 3'h0;
         byte_cnt <= 2'h0;
         opcode <= 8'h00;
         data_one <= 8'h00;
         data_two <= 8'h00;
      end else if (sck_rise) begin
         shift_in <= {shift_in[5:0], mosi_s[1]};
         bit_cnt <= bit_cnt + 3'h1;
         if (bit_cnt == LAST_BIT) begin
            if (byte_cnt == 2'h0) opcode <= {shift_in, mosi_s[1]};
            if (byte_cnt == 2'h1) data_one <= {shift_in, mosi_s[1]};
            if (byte_cnt == 2'h2) data_two <= {shift_in, mosi_s[1]};
            if (byte_cnt != BYTE_MAX) byte_cnt <= byte_cnt + 2'h1;
         end
      end
   end

   // ****************************************************
   // command classification
   // ****************************************************
   logic full_op, aligned, data_ok, is_other, is_guarded;
   logic is_wsr1, is_wsr2, is_lockcmd, is_protcmd;
   logic [N_OTHER-1:0] other_hit;

   for (genvar i = 0; i < N_OTHER; i++) begin : g_match
      assign other_hit[i] = opcode == OTHER_OPS[i*8 +: 8];
   end

   assign full_op = byte_cnt != 2'h0;
   assign aligned = bit_cnt == 3'h0;
   assign data_ok = byte_cnt >= 2'h2 && aligned;
   assign is_other = |other_hit;
   assign is_wsr1 = opcode == OP_WSR1;
   assign is_wsr2 = opcode == OP_WSR2;
   assign is_lockcmd = opcode == OP_LOCKDN || opcode == OP_FREEZE;
   assign is_protcmd = opcode == OP_PROT || opcode == OP_UNPROT;
   // an opcode still arriving is never guarded
   assign is_guarded = full_op & (is_other | is_wsr1 | is_wsr2 |
                       is_lockcmd | is_protcmd);

   // ****************************************************
   // hold abort
   // ****************************************************
   logic dead, hold_kill;
   assign hold_kill = in_frame & ~hold_s[1] & is_guarded & ~dead;

   // a held guarded frame is dead until chip select falls again
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || cs_fall) dead <= 1'b0;
      else if (hold_kill) dead <= 1'b1;
   end

   // ****************************************************
   // status fields
   // ****************************************************
   logic lock, write_latch_bit, fail, rst_allow, lck_allow, frozen;
   logic end_ok, wsr1_go, wsr1_block, srst_go;

   assign end_ok = cs_rise & ~dead;
   assign wsr1_block = wp_on & ~data_one[LOCK_POS];
   assign wsr1_go = end_ok & write_latch_bit & is_wsr1 & data_ok & ~wsr1_block;
   // the confirmation byte is the one straight after the opcode
   assign srst_go = end_ok & rst_allow & opcode == OP_SRST &&
                    data_ok && data_one == SRST_CONFIRM;

   // lock bit: only written by an accepted status write one
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) lock <= LOCK_RST;
      else if (wsr1_go) lock <= data_one[LOCK_POS];
   end

   // global action decided with the lock value before the write
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         global_req_out <= 1'b0;
         global_code_out <= 4'h0;
      end else begin
         global_req_out <= wsr1_go & ~lock;
         if (wsr1_go) global_code_out <= data_one[GCODE_HI:GCODE_LO];
      end
   end

   // write latch; clears win over a set arriving together
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) write_latch_bit <= LATCH_RST;
      else if (srst_go) write_latch_bit <= 1'b0;
      else if (op_done_in || op_abort_in) write_latch_bit <= 1'b0;
      else if (hold_kill) write_latch_bit <= 1'b0;
      else if (end_ok && full_op && aligned && opcode == OP_WREN) write_latch_bit <= 1'b1;
      else if (end_ok && full_op && opcode == OP_WRDI) write_latch_bit <= 1'b0;
      else if (end_ok && is_guarded) write_latch_bit <= 1'b0;
   end

   // fail flag moves only on a finished operation
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) fail <= FAIL_RST;
      else if (op_done_in) fail <= op_fail_in;
   end

   // soft reset request leaves lock and both allow bits alone
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) soft_reset_out <= 1'b0;
      else soft_reset_out <= srst_go;
   end

   // reset allow written by status write two only
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) rst_allow <= RST_ALLOW_RST;
      else if (end_ok && write_latch_bit && is_wsr2 && data_ok)
         rst_allow <= data_one[RST_ALLOW_POS];
   end

   // freeze is permanent until power is cycled
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) frozen <= 1'b0;
      else if (freeze_done_in) frozen <= 1'b1;
   end

   // lockdown allow: no automatic clear except freeze
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) lck_allow <= LCK_ALLOW_RST;
      else if (freeze_done_in || frozen) lck_allow <= 1'b0;
      else if (end_ok && write_latch_bit && is_wsr2 && data_ok)
         lck_allow <= data_one[LCK_ALLOW_POS];
   end

   // ****************************************************
   // acceptance seen by the array sequencer
   // ****************************************************
   logic next_accept;
   always_comb begin
      next_accept = in_frame & ~dead & write_latch_bit & is_guarded;
      if (is_lockcmd && !lck_allow) next_accept = 1'b0;
      if (is_protcmd && lock) next_accept = 1'b0;
      if (is_wsr1 || is_wsr2) next_accept = 1'b0;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         cmd_accept_out <= 1'b0;
         cmd_opcode_out <= 8'h00;
      end else begin
         cmd_accept_out <= next_accept;
         cmd_opcode_out <= opcode;
      end
   end

   // ****************************************************
   // status images
   // ****************************************************
   logic [1:0] soft_protect_summary;
   logic [7:0] next_one, next_two;
   always_comb begin
      soft_protect_summary = prot_all_in ? SWP_ALL :
            (prot_none_in ? SWP_NONE : SWP_SOME);
      next_one = 8'h00;
      next_one[LOCK_POS] = lock;
      next_one[FAIL_POS] = fail;
      next_one[PIN_POS] = wp_s[1];
      next_one[SWP_HI:SWP_LO] = soft_protect_summary;
      next_one[LATCH_POS] = write_latch_bit;
      next_one[BUSY_POS] = op_busy_in;
      next_two = 8'h00;
      next_two[RST_ALLOW_POS] = rst_allow;
      next_two[LCK_ALLOW_POS] = lck_allow;
      next_two[BUSY_POS] = op_busy_in;
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         status_one_out <= 8'h00;
         status_two_out <= 8'h00;
      end else begin
         status_one_out <= next_one;
         status_two_out <= next_two;
      end
   end

   // ****************************************************
   // status read out, bytes one and two alternate
   // ****************************************************
   logic rd_active, rd_sel;
   logic [6:0] out_sh;
   assign rd_active = in_frame & full_op & opcode == OP_RDSR;

   // fresh image per byte so busy polling sees updates
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || cs_fall) begin
         miso_out <= 1'b0;
         out_sh <= 7'h00;
         rd_sel <= 1'b0;
      end else if (sck_fall && rd_active && aligned) begin
         miso_out <= rd_sel ? status_two_out[7] : status_one_out[7];
         out_sh <= rd_sel ? status_two_out[6:0] : status_one_out[6:0];
         rd_sel <= ~rd_sel;
      end else if (sck_fall && rd_active) begin
         miso_out <= out_sh[6];
         out_sh <= {out_sh[5:0], 1'b0};
      end
   end

   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) miso_oe_n_out <= 1'b1;
      else miso_oe_n_out <= ~rd_active;
   end

   // ****************************************************
   // checks
   // ****************************************************
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);

   lock_no_clear_a: assert property (
      lock && wp_on |=> lock)
      else $error("lock cleared while protect pin asserted");
   global_old_lock_a: assert property (
      global_req_out |-> !$past(lock) && $past(wsr1_go))
      else $error("global action with lock set");
   wel_wsr_end_a: assert property (
      end_ok && is_wsr1 && !data_ok |=> !write_latch_bit && $stable(lock))
      else $error("short status write did not abort");
   wel_blocked_a: assert property (
      end_ok && is_wsr1 && data_ok && wsr1_block |=> !write_latch_bit && $stable(lock))
      else $error("blocked lock clear not ignored");
   fail_update_a: assert property (
      op_done_in |=> fail == $past(op_fail_in))
      else $error("fail flag not updated");
   fail_abort_a: assert property (
      op_abort_in && !op_done_in |=> $stable(fail))
      else $error("abort changed fail flag");
   pin_mirror_a: assert property (
      $past(rst_n_in) |-> status_one_out[PIN_POS] == $past(wp_s[1]))
      else $error("pin state bit wrong");
   swp_code_a: assert property (
      status_one_out[SWP_HI:SWP_LO] != 2'h2)
      else $error("reserved summary code");
   srst_allow_a: assert property (
      soft_reset_out |-> $past(rst_allow) && !write_latch_bit)
      else $error("soft reset while not allowed");
   srst_keep_a: assert property (
      soft_reset_out |=> ($stable(lck_allow) && $stable(rst_allow)) [*2])
      else $error("soft reset changed allow bits");
   freeze_a: assert property (
      freeze_done_in |=> !lck_allow ##1 !lck_allow)
      else $error("lockdown allow not forced low");
   lockcmd_a: assert property (
      cmd_accept_out |-> $past(write_latch_bit) &&
         !($past(is_lockcmd) && !$past(lck_allow)))
      else $error("guarded command accepted illegally");

   wsr1_c: cover property (wsr1_go ##1 global_req_out);
   srst_c: cover property (srst_go ##1 soft_reset_out);
   rdsr_c: cover property (!miso_oe_n_out ##[1:300] miso_oe_n_out);
   hold_c: cover property (hold_kill);

endmodule

/* File: sfsr_host.sv */
// spi host model that clocks command frames into the status logic
`timescale 1ns/1ps
module sfsr_host (
   input wire logic clk_in,
   input wire logic miso_in,
   output logic sck_out,
   output logic cs_n_out,
   output logic mosi_out,
   output logic hold_n_out
);
   // ****************
   // frame engine
   // ****************
   int half = 8; // ref clocks per sck phase, 80 ns per sck period
   // idle pins: deselected, clock parked low
   initial begin
      sck_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
      hold_n_out = 1'b1;
   end
   // mode 0: data moves while sck is low, device samples on the rise
   task automatic xfer(input logic [23:0] d, input int n, input logic kill,
      output logic [23:0] rx);
      rx = 24'h000000;
      @(posedge clk_in) cs_n_out <= 1'b0;
      for (int i = 0; i < n; i++) begin
         mosi_out <= d[23-i];
         repeat (half) @(posedge clk_in);
         sck_out <= 1'b1;
         rx = {rx[22:0], miso_in};
         repeat (half) @(posedge clk_in);
         sck_out <= 1'b0;
      end
      // hold inside an open guarded frame kills it
      if (kill) begin
         @(posedge clk_in) hold_n_out <= 1'b0;
         repeat (half) @(posedge clk_in);
      end
      @(posedge clk_in) cs_n_out <= 1'b1;
      hold_n_out <= 1'b1;
      mosi_out <= ~mosi_out; // released data line must not look valid
      repeat (8) @(posedge clk_in); // gap, and time for effects to land
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the serial flash status register logic
`timescale 1ns/1ps
module testbench;
   import sfsr_pkg::*;
   // ****************
   // hookup
   // ****************
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic wp_n_in = 1'b1;
   logic op_busy_in = 1'b0;
   logic [3:0] arr_q = 4'h0; // done, fail, abort, freeze pulses
   logic prot_none_in = 1'b1;
   logic prot_all_in = 1'b0;
   logic sck, cs_n, mosi, hold_n, miso, miso_oe_n, greq, srst;
   logic snap = 1'b0;
   logic [7:0] s1, s2;
   logic [3:0] gcode;
   logic [23:0] rx;
   logic [4:0] exp_ev;
   logic e_lock = 0, e_fail = 0, e_latch = 0, e_ra = 0, e_la = 0;
   logic [15:0] st_q[$];
   logic [4:0] ev_q[$];
   int errors = 0;
   int checks_done = 0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   sfsr_core u_dut (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sck_in(sck),
      .cs_n_in(cs_n), .mosi_in(mosi), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
      .op_busy_in(op_busy_in), .op_done_in(arr_q[3]), .op_fail_in(arr_q[2]),
      .op_abort_in(arr_q[1]), .freeze_done_in(arr_q[0]),
      .prot_none_in(prot_none_in), .prot_all_in(prot_all_in),
      .miso_out(miso), .miso_oe_n_out(miso_oe_n), .status_one_out(s1),
      .status_two_out(s2), .cmd_opcode_out(), .cmd_accept_out(),
      .global_req_out(greq), .global_code_out(gcode), .soft_reset_out(srst));
   // a released data pin reads high through the board pull-up
   sfsr_host u_host (.clk_in(ref_clk_in), .miso_in(miso_oe_n ? 1'b1 : miso),
      .sck_out(sck), .cs_n_out(cs_n), .mosi_out(mosi), .hold_n_out(hold_n));
   // ****************
   // helpers
   // ****************
   task automatic cmp(input string what, input logic [23:0] e,
      input logic [23:0] g);
      checks_done++;
      if (e !== g) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // expected status bytes built from the tracked state and live inputs
   function automatic logic [15:0] exp_st();
      logic [7:0] b1;
      logic [7:0] b2;
      b1 = 8'h00;
      b2 = 8'h00;
      b1[LOCK_POS] = e_lock;
      b1[FAIL_POS] = e_fail;
      b1[PIN_POS] = wp_n_in;
      b1[SWP_HI:SWP_LO] = prot_all_in ? SWP_ALL :
         (prot_none_in ? SWP_NONE : SWP_SOME);
      b1[LATCH_POS] = e_latch;
      b1[BUSY_POS] = op_busy_in;
      b2[RST_ALLOW_POS] = e_ra;
      b2[LCK_ALLOW_POS] = e_la;
      b2[BUSY_POS] = op_busy_in;
      return {b1, b2};
   endfunction
   task automatic chk();
      st_q.push_back(exp_st());
      @(posedge ref_clk_in) snap <= 1'b1;
      @(posedge ref_clk_in) snap <= 1'b0;
   endtask
   task automatic frame(input logic [23:0] d, input int n,
      input logic kill = 1'b0);
      u_host.xfer(d, n, kill, rx);
   endtask
   task automatic wren();
      frame(24'h060000, 8);
      e_latch = 1'b1;
   endtask
   // latched byte-one write; the global action keys off the old lock
   task automatic wsr1(input logic [7:0] d);
      wren();
      if (d[LOCK_POS] || wp_n_in) begin
         if (!e_lock) ev_q.push_back({1'b0, d[GCODE_HI:GCODE_LO]});
         e_lock = d[LOCK_POS];
      end
      frame({OP_WSR1, d, 8'h00}, 16);
      e_latch = 1'b0;
      chk();
   endtask
   task automatic arr(input logic [3:0] p);
      @(posedge ref_clk_in) arr_q <= p;
      @(posedge ref_clk_in) arr_q <= 4'h0;
      repeat (4) @(posedge ref_clk_in);
   endtask
   task automatic set_wp(input logic p);
      @(posedge ref_clk_in) wp_n_in <= p;
      repeat (6) @(posedge ref_clk_in);
   endtask
   // ****************
   // monitor: oldest note against each result that shows up
   // ****************
   always @(posedge ref_clk_in) begin
      if (snap === 1'b1)
         cmp("status", {8'h00, st_q.pop_front()}, {8'h00, s1, s2});
      if (greq === 1'b1 || srst === 1'b1) begin
         exp_ev = (ev_q.size() > 0) ? ev_q.pop_front() : 5'h1F;
         cmp("event", {19'h0, exp_ev}, {19'h0, srst, greq ? gcode : 4'h0});
      end
   end
   // a hang is cut short here
   initial begin
      repeat (100000) @(posedge ref_clk_in);
      errors++;
      report_and_stop();
   end
   // ****************
   // main sequence
   // ****************
   initial begin
      void'($urandom(80357));
      repeat (5) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      repeat (6) @(posedge ref_clk_in);
      chk();
      for (int k = 0; k < 3; k++) begin
         prot_none_in <= (k == 0);
         prot_all_in <= (k == 2);
         repeat (4) @(posedge ref_clk_in);
         chk();
      end
      set_wp(1'b0);
      chk();
      set_wp(1'b1);
      frame({OP_WSR1, 8'h80, 8'h00}, 16);
      chk();
      wsr1(8'($urandom) | 8'h80);
      wsr1(8'($urandom) & 8'h7F);
      set_wp(1'b0);
      wsr1(8'($urandom) & 8'h7F);
      wsr1(8'($urandom) | 8'h80);
      wsr1(8'($urandom) & 8'h7F);
      set_wp(1'b1);
      // short data byte, then a stop off the byte boundary
      for (int n = 13; n < 21; n += 7) begin
         wren();
         frame({OP_WSR1, 16'h0000}, n);
         e_latch = 1'b0;
         chk();
      end
      wren();
      frame({OP_WSR1, 16'h0000}, 16, 1'b1);
      e_latch = 1'b0;
      chk();
      wren();
      frame(24'h010000, 5);
      chk();
      frame(24'h040000, 8);
      e_latch = 1'b0;
      chk();
      frame({OP_SRST, SRST_CONFIRM, 8'h00}, 16);
      chk();
      wren();
      frame({OP_WSR2, 8'h18, 8'h00}, 16);
      {e_latch, e_ra, e_la} = 3'b011;
      chk();
      wren();
      ev_q.push_back(5'h10);
      frame({OP_SRST, SRST_CONFIRM, 8'h00}, 16);
      e_latch = 1'b0;
      chk();
      arr(4'b0001);
      e_la = 1'b0;
      chk();
      wren();
      frame({OP_WSR2, 8'h08, 8'h00}, 16);
      {e_latch, e_ra} = 2'b00;
      chk();
      op_busy_in <= 1'b1;
      u_host.xfer({8'h05, 16'h0000}, 24, 1'b0, rx);
      cmp("read", {8'h00, exp_st()}, {8'h00, rx[15:0]});
      op_busy_in <= 1'b0;
      wren();
      arr(4'b0010);
      e_latch = 1'b0;
      chk();
      wren();
      arr(4'b1100);
      {e_fail, e_latch} = 2'b10;
      chk();
      arr(4'b1000);
      e_fail = 1'b0;
      chk();
      cmp("events left", 24'h0, 24'(ev_q.size()));
      report_and_stop();
   end
endmodule
